/* File: src/osc_pkg.sv */
// Package of shared constants and helpers for the oscillator select control block
// =====================================================================
// Function
// - Select codes: 000 divided fast RC, 001 PLL, 010 primary, 100 secondary, 101 low-power RC
// - Reserved select codes 011, 110 and 111 act as code 000
// - Reset loads the new clock select field from boot select config bits
// - Lock bit set freezes clock and PLL selections; clear allows changes
// - Sleep-on-wait set: wait instruction means sleep; clear means idle
// - Clock fail flag reads one once the fail-safe monitor detects failure
// - Secondary oscillator enable bit turns that oscillator on or off
// - Software sets switch request; device clears it when the switch completes
// - Switch request resets to the two-speed startup config bit
// - Secondary oscillator enable resets to its config bit
// - Control register writes are refused until the unlock sequence completes
// - Bits 6 to 5 and bit 2 read as zero
package osc_pkg;

  // =====================================================================
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_KEY = 8'h04;
  localparam logic [7:0] OFF_IRQ_STS = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_STATE = 8'h10;

  // =====================================================================
  // Control register field positions
  localparam int NCS_LSB = 8;
  localparam int LOCK_BIT = 7;
  localparam int SLEEP_BIT = 4;
  localparam int CF_BIT = 3;
  localparam int SECONDARY_OSC_BIT = 1;
  localparam int REQ_BIT = 0;

  // Interrupt status bit positions and width
  localparam int IRQ_FAIL = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_DENY = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // Unlock key words, written in this order
  localparam logic [31:0] KEY_FIRST = 32'hAA99_6655;
  localparam logic [31:0] KEY_SECOND = 32'h5566_99AA;

  // =====================================================================
  // Clock source codes
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRIMARY_OSC = 3'h2;
  localparam logic [2:0] SRC_SECONDARY_OSC = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
  localparam int SRC_COUNT = 5;

  // =====================================================================
  // Timing: settle time after the new source reports ready
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_NS = 100;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  // Map a select code onto the source it really picks
  function automatic logic [2:0] eff_src(input logic [2:0] code);
    unique case (code)
      SRC_PLL, SRC_PRIMARY_OSC, SRC_SECONDARY_OSC, SRC_LOW_POWER_RC_OSC: eff_src = code;
      default: eff_src = SRC_FRC;
    endcase
  endfunction

  // Index of a source into the ready vector
  function automatic logic [2:0] rdy_idx(input logic [2:0] src);
    unique case (src)
      SRC_PLL: rdy_idx = 3'h1;
      SRC_PRIMARY_OSC: rdy_idx = 3'h2;
      SRC_SECONDARY_OSC: rdy_idx = 3'h3;
      SRC_LOW_POWER_RC_OSC: rdy_idx = 3'h4;
      default: rdy_idx = 3'h0;
    endcase
  endfunction

endpackage

/* File: src/osc_sync2.sv */
// Two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/10ps
module osc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [W-1:0] d_i, // Asynchronous levels
  output logic [W-1:0] q_o // Synchronised levels
);

  logic [W-1:0] meta_reg;

  // =====================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule

/* File: src/osc_switch_seq.sv */
// Clock switch sequencer: waits for the target to be ready, settles, commits
`timescale 1ns/10ps
module osc_switch_seq #(
  parameter int SETTLE = osc_pkg::SETTLE_CYC
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [2:0] preset_src_i, // Source running out of reset
  input wire logic req_i, // Switch request level
  input wire logic [2:0] tgt_i, // Requested select code
  input wire logic [osc_pkg::SRC_COUNT-1:0] rdy_i, // Synced ready per source
  output logic [2:0] cur_src_o, // Active source
  output logic busy_o, // Switch in progress
  output logic done_o // One-cycle completion pulse
);

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_SETTLE, S_FINISH} osc_seq_t;
  osc_seq_t state_reg;
  logic [2:0] tgt_reg;
  logic [7:0] cnt_reg;

  // =====================================================================
  // Sequence; FINISH gives the completion one cycle to clear the request bit,
  // so a request set again in that cycle starts a new switch instead of hanging
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      tgt_reg <= osc_pkg::SRC_FRC;
      cnt_reg <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_reg)
        S_IDLE: if (req_i) begin
          tgt_reg <= osc_pkg::eff_src(tgt_i);
          busy_o <= 1'b1;
          state_reg <= S_WAIT;
        end
        S_WAIT: if (rdy_i[osc_pkg::rdy_idx(tgt_reg)]) begin
          cnt_reg <= 8'(SETTLE - 1);
          state_reg <= S_SETTLE;
        end
        S_SETTLE: if (cnt_reg == 8'h00) begin
          done_o <= 1'b1;
          busy_o <= 1'b0;
          state_reg <= S_FINISH;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        S_FINISH: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // Active source changes only as the switch completes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_src_o <= preset_src_i;
    end else if (state_reg == S_SETTLE && cnt_reg == 8'h00) begin
      cur_src_o <= tgt_reg;
    end
  end

endmodule

/* File: src/osc_sel_ctrl.sv */
// Oscillator select control: control register, unlock, switch control, interrupts
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module osc_sel_ctrl #(
  parameter int SETTLE = osc_pkg::SETTLE_CYC
) (
  input wire logic clk_i, // System clock, 250 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [2:0] cfg_boot_src_i, // Boot clock select config bits
  input wire logic cfg_two_speed_i, // Two-speed startup config bit
  input wire logic cfg_secondary_osc_en_i, // Secondary oscillator enable config bit
  input wire logic [osc_pkg::SRC_COUNT-1:0] osc_ready_i, // Source ready, async
  input wire logic fail_detect_i, // Fail-safe monitor failure, async
  input wire logic wait_exec_i, // Wait instruction executed, pulse
  output logic [2:0] cur_src_o, // Active clock source
  output logic switch_busy_o, // Clock switch in progress
  output logic secondary_osc_en_o, // Secondary oscillator enable
  output logic clk_lock_o, // Clock and PLL selection locked
  output logic sleep_o, // Enter sleep, pulse
  output logic idle_o, // Enter idle, pulse
  output logic irq_o // Interrupt, level
);

  // =====================================================================
  // Declarations
  localparam int IRQ_W_L = osc_pkg::IRQ_W;
  typedef enum logic [1:0] {K_LOCKED, K_HALF, K_OPEN} osc_key_t;
  osc_key_t key_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [2:0] ncs_reg;
  logic lock_reg;
  logic sleep_reg;
  logic cf_reg;
  logic secondary_osc_reg;
  logic req_reg;
  logic [IRQ_W_L-1:0] sts_reg;
  logic [IRQ_W_L-1:0] sts_next;
  logic [IRQ_W_L-1:0] mask_reg;
  logic [IRQ_W_L-1:0] mask_next;
  logic irq_reg;
  logic sleep_p_reg;
  logic idle_p_reg;
  logic fail_q_reg;
  logic [osc_pkg::SRC_COUNT:0] sync_q;
  logic fail_sync;
  logic fail_rise;
  logic take;
  logic wr;
  logic rd;
  logic wr_ctrl;
  logic ctrl_open;
  logic ncs_try;
  logic req_try;
  logic deny_ev;
  logic [31:0] rd_mux;
  logic [2:0] seq_src;
  logic seq_busy;
  logic seq_done;
  logic [2:0] preset_src;
  logic [31:0] mask_merged;

  // Apply byte lane enables to a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    lane_merge = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

  // =====================================================================
  // Synchronisers for oscillator ready lines and the failure detector
  osc_sync2 #(
    .W(osc_pkg::SRC_COUNT + 1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({fail_detect_i, osc_ready_i}),
    .q_o(sync_q)
  );

  assign fail_sync = sync_q[osc_pkg::SRC_COUNT];

  // Edge of the failure level, taken after the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_q_reg <= 1'b0;
    end else begin
      fail_q_reg <= fail_sync;
    end
  end

  assign fail_rise = fail_sync & ~fail_q_reg;

  // =====================================================================
  // Wishbone classic slave: one wait state, ack drops the cycle after
  assign take = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = take & wb_we_i;
  assign rd = take & ~wb_we_i;
  assign wr_ctrl = wr && wb_adr_i == osc_pkg::OFF_CTRL;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= take;
    end
  end

  // Read data is captured when the request is taken; zero for writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (take) begin
      dat_reg <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Read multiplexer; unmapped addresses read zero and still acknowledge
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      osc_pkg::OFF_CTRL: begin
        rd_mux[osc_pkg::NCS_LSB +: 3] = ncs_reg;
        rd_mux[osc_pkg::LOCK_BIT] = lock_reg;
        rd_mux[osc_pkg::SLEEP_BIT] = sleep_reg;
        rd_mux[osc_pkg::CF_BIT] = cf_reg;
        rd_mux[osc_pkg::SECONDARY_OSC_BIT] = secondary_osc_reg;
        rd_mux[osc_pkg::REQ_BIT] = req_reg; // bits 6..5 and 2 stay zero
      end
      osc_pkg::OFF_IRQ_STS: rd_mux[IRQ_W_L-1:0] = sts_reg;
      osc_pkg::OFF_IRQ_MASK: rd_mux[IRQ_W_L-1:0] = mask_reg;
      osc_pkg::OFF_STATE: rd_mux[4:0] = {seq_busy, 1'b0, seq_src};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // =====================================================================
  // Unlock sequence: two key words back to back on the key register.
  // Any other write while half open, except the first key again, relocks, so stray code cannot open it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_reg <= K_LOCKED;
    end else if (wr && wb_adr_i == osc_pkg::OFF_KEY) begin
      if (wb_sel_i == 4'hF && wb_dat_i == osc_pkg::KEY_FIRST) begin
        key_reg <= K_HALF;
      end else if (wb_sel_i == 4'hF && key_reg == K_HALF && wb_dat_i == osc_pkg::KEY_SECOND) begin
        key_reg <= K_OPEN;
      end else begin
        key_reg <= K_LOCKED;
      end
    end else if (wr && key_reg == K_HALF) begin
      key_reg <= K_LOCKED;
    end
  end

  assign ctrl_open = key_reg == K_OPEN;

  // Lock guard on the clock selection and on starting a switch
  assign ncs_try = wr_ctrl & wb_sel_i[1];
  assign req_try = wr_ctrl & wb_sel_i[0] & wb_dat_i[osc_pkg::REQ_BIT];
  assign deny_ev = wr_ctrl & (~ctrl_open | (lock_reg & (ncs_try | req_try)));

  // =====================================================================
  // New clock select field: boot config at reset, frozen by the lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ncs_reg <= cfg_boot_src_i;
    end else if (ncs_try && ctrl_open && !lock_reg) begin
      ncs_reg <= wb_dat_i[osc_pkg::NCS_LSB +: 3];
    end
  end

  // Lock bit: software can only set it; it holds until the next reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_reg <= 1'b0;
    end else if (wr_ctrl && ctrl_open && wb_sel_i[0] && wb_dat_i[osc_pkg::LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  // Sleep-on-wait and secondary oscillator enable are not covered by the lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_reg <= 1'b0;
      secondary_osc_reg <= cfg_secondary_osc_en_i;
    end else if (wr_ctrl && ctrl_open && wb_sel_i[0]) begin
      sleep_reg <= wb_dat_i[osc_pkg::SLEEP_BIT];
      secondary_osc_reg <= wb_dat_i[osc_pkg::SECONDARY_OSC_BIT];
    end
  end

  // Clock fail flag: a new failure beats a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cf_reg <= 1'b0;
    end else if (fail_rise) begin
      cf_reg <= 1'b1;
    end else if (wr_ctrl && ctrl_open && wb_sel_i[0] && !wb_dat_i[osc_pkg::CF_BIT]) begin
      cf_reg <= 1'b0;
    end
  end

  // Switch request: software sets, completion clears, a set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_reg <= cfg_two_speed_i;
    end else if (req_try && ctrl_open && !lock_reg) begin
      req_reg <= 1'b1;
    end else if (seq_done) begin
      req_reg <= 1'b0;
    end
  end

  // =====================================================================
  // Switch sequencer. With two-speed startup the part runs on the fast RC
  // first and then switches to the boot selection.
  assign preset_src = cfg_two_speed_i ? osc_pkg::SRC_FRC : osc_pkg::eff_src(cfg_boot_src_i);

  osc_switch_seq #(
    .SETTLE(SETTLE)
  ) u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .preset_src_i(preset_src),
    .req_i(req_reg),
    .tgt_i(ncs_reg),
    .rdy_i(sync_q[osc_pkg::SRC_COUNT-1:0]),
    .cur_src_o(seq_src),
    .busy_o(seq_busy),
    .done_o(seq_done)
  );

  assign cur_src_o = seq_src;
  assign switch_busy_o = seq_busy;

  // Level outputs that follow the control bits
  assign secondary_osc_en_o = secondary_osc_reg;
  assign clk_lock_o = lock_reg;

  // =====================================================================
  // Wait instruction: sleep or idle request, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_p_reg <= 1'b0;
      idle_p_reg <= 1'b0;
    end else begin
      sleep_p_reg <= wait_exec_i & sleep_reg;
      idle_p_reg <= wait_exec_i & ~sleep_reg;
    end
  end

  assign sleep_o = sleep_p_reg;
  assign idle_o = idle_p_reg;

  // =====================================================================
  // Interrupt status: sticky, cleared by reading it, new events win
  always_comb begin
    sts_next = sts_reg;
    if (rd && wb_adr_i == osc_pkg::OFF_IRQ_STS) begin
      sts_next = '0;
    end
    if (fail_rise) begin
      sts_next[osc_pkg::IRQ_FAIL] = 1'b1;
    end
    if (seq_done) begin
      sts_next[osc_pkg::IRQ_DONE] = 1'b1;
    end
    if (deny_ev) begin
      sts_next[osc_pkg::IRQ_DENY] = 1'b1;
    end
  end

  // Mask register, byte lane zero only
  always_comb begin
    mask_merged = lane_merge({29'h0, mask_reg}, wb_dat_i, wb_sel_i);
    mask_next = mask_reg;
    if (wr && wb_adr_i == osc_pkg::OFF_IRQ_MASK) begin
      mask_next = mask_merged[IRQ_W_L-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_reg <= '0;
      mask_reg <= osc_pkg::IRQ_MASK_RST;
      irq_reg <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      mask_reg <= mask_next;
      irq_reg <= |(sts_next & mask_next);
    end
  end

  assign irq_o = irq_reg;

endmodule

/* File: verification/osc_sel_ctrl_properties.sv */
// Checker for the oscillator select control block, bound to its ports
`timescale 1ns/10ps
module osc_sel_ctrl_chk #(
  parameter int SETTLE = 2
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Bus address
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic [2:0] cfg_boot_src_i, // Boot select config
  input wire logic cfg_two_speed_i, // Two-speed config
  input wire logic cfg_secondary_osc_en_i, // Secondary enable config
  input wire logic wait_exec_i, // Wait pulse
  input wire logic [2:0] cur_src_o, // Active source
  input wire logic switch_busy_o, // Switch busy
  input wire logic secondary_osc_en_o, // Secondary enable
  input wire logic clk_lock_o, // Lock
  input wire logic sleep_o, // Sleep pulse
  input wire logic idle_o, // Idle pulse
  input wire logic irq_o // Interrupt
);
  // =====================================================================
  // Helpers
  default clocking cb @(posedge clk_i); endclocking
  logic rd_take;
  // Reserved codes fall back to the fast RC, so reset must map them the same way
  function automatic logic [2:0] boot_map(input logic [2:0] c);
    boot_map = (c == 3'h1 || c == 3'h2 || c == 3'h4 || c == 3'h5) ? c : 3'h0;
  endfunction
  // A read request being taken this edge
  assign rd_take = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  // =====================================================================
  // Properties
  AST_ACK_LAT: assert property (disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_WAIT_ONE: assert property (disable iff (rst_i) wait_exec_i |=> sleep_o != idle_o)
    else $error("wait gave no single low-power pulse");
  AST_NO_WAIT: assert property (disable iff (rst_i) !wait_exec_i |=> !sleep_o && !idle_o)
    else $error("low-power pulse without wait");
  AST_RST_OUT: assert property (rst_i |=> secondary_osc_en_o == $past(cfg_secondary_osc_en_i) && !clk_lock_o && !irq_o)
    else $error("outputs wrong after reset");
  AST_RST_SRC: assert property (rst_i |=>
    cur_src_o == ($past(cfg_two_speed_i) ? 3'h0 : boot_map($past(cfg_boot_src_i))))
    else $error("source wrong after reset");
  AST_LOCK_HOLD: assert property (disable iff (rst_i) clk_lock_o |=> clk_lock_o)
    else $error("lock dropped without reset");
  AST_SRC_STABLE: assert property (disable iff (rst_i) $changed(cur_src_o) |->
    $past(switch_busy_o) || $past(switch_busy_o, 2))
    else $error("source changed outside a switch");
  AST_CTRL_RSVD: assert property (disable iff (rst_i) rd_take && wb_adr_i == osc_pkg::OFF_CTRL |=>
    wb_dat_o[6:5] == 2'h0 && !wb_dat_o[2])
    else $error("unimplemented control bits read nonzero");
  AST_CTRL_MIRROR: assert property (disable iff (rst_i) rd_take && wb_adr_i == osc_pkg::OFF_CTRL |=>
    wb_dat_o[1] == secondary_osc_en_o && wb_dat_o[7] == clk_lock_o)
    else $error("control read disagrees with outputs");
  AST_KEY_RD0: assert property (disable iff (rst_i) rd_take && wb_adr_i == osc_pkg::OFF_KEY |=>
    wb_dat_o == 32'h0000_0000)
    else $error("key register read nonzero");
endmodule

bind osc_sel_ctrl osc_sel_ctrl_chk #(.SETTLE(SETTLE)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cfg_boot_src_i(cfg_boot_src_i), .cfg_two_speed_i(cfg_two_speed_i), .cfg_secondary_osc_en_i(cfg_secondary_osc_en_i),
  .wait_exec_i(wait_exec_i), .cur_src_o(cur_src_o), .switch_busy_o(switch_busy_o), .secondary_osc_en_o(secondary_osc_en_o),
  .clk_lock_o(clk_lock_o), .sleep_o(sleep_o), .idle_o(idle_o), .irq_o(irq_o));

/* File: verification/testbench.sv */
// Self-checking testbench for the oscillator select control block
`timescale 1ns/10ps
module testbench;
  // =====================================================================
  // Signals
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic wb_ack_o, switch_busy_o, secondary_osc_en_o, clk_lock_o, sleep_o, idle_o, irq_o;
  logic [2:0] cur_src_o, exp_src;
  logic [4:0] osc_ready_i = 5'h00;
  logic fail_detect_i = 1'b0, wait_exec_i = 1'b0;
  logic [2:0] cfg_boot_src_i = 3'h2;
  logic cfg_two_speed_i = 1'b1, cfg_secondary_osc_en_i = 1'b1;
  logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3, 3'h6, 3'h7};
  int bad_count = 0, check_count = 0, cycles = 0;

  osc_sel_ctrl #(.SETTLE(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cfg_boot_src_i(cfg_boot_src_i), .cfg_two_speed_i(cfg_two_speed_i),
    .cfg_secondary_osc_en_i(cfg_secondary_osc_en_i),
    .osc_ready_i(osc_ready_i), .fail_detect_i(fail_detect_i), .wait_exec_i(wait_exec_i),
    .cur_src_o(cur_src_o), .switch_busy_o(switch_busy_o), .secondary_osc_en_o(secondary_osc_en_o), .clk_lock_o(clk_lock_o),
    .sleep_o(sleep_o), .idle_o(idle_o), .irq_o(irq_o));

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  // =====================================================================
  // Tasks
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; the master waits for ack with no assumed latency, the hang guard bounds it
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, adr, d, r);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, adr, 32'h0000_0000, r);
    check(r, exp);
  endtask

  // Poll until the request bit clears; bounded so a stuck switch cannot hang
  task automatic sw_wait;
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      wb(1'b0, osc_pkg::OFF_CTRL, 32'h0000_0000, r);
      n++;
    end while (r[0] !== 1'b0 && n < 40);
    if (n >= 40) bad_count++;
  endtask

  task automatic pulse_wait(input logic [1:0] exp);
    @(posedge clk_i) wait_exec_i <= 1'b1;
    @(posedge clk_i) wait_exec_i <= 1'b0;
    @(posedge clk_i);
    check({30'h0, sleep_o, idle_o}, {30'h0, exp});
  endtask

  // Hang guard: counts a mismatch and closes the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  // =====================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset image: boot code, pending two-speed switch, secondary enabled
    rd(osc_pkg::OFF_CTRL, 32'h0000_0203);
    rd(osc_pkg::OFF_STATE, 32'h0000_0010);
    // Completing the start-up switch once the primary is ready
    @(posedge clk_i) osc_ready_i <= 5'h04;
    sw_wait();
    check({29'h0, cur_src_o}, {29'h0, osc_pkg::SRC_PRIMARY_OSC});
    rd(osc_pkg::OFF_IRQ_STS, 32'h0000_0002);
    rd(osc_pkg::OFF_IRQ_STS, 32'h0000_0000);
    // Write without unlock is refused and flagged
    wr(osc_pkg::OFF_CTRL, 32'h0000_0312);
    rd(osc_pkg::OFF_CTRL, 32'h0000_0202);
    rd(osc_pkg::OFF_IRQ_STS, 32'h0000_0004);
    // Every select code, reserved ones included
    @(posedge clk_i) osc_ready_i <= 5'h1F;
    wr(osc_pkg::OFF_KEY, osc_pkg::KEY_FIRST);
    wr(osc_pkg::OFF_KEY, osc_pkg::KEY_SECOND);
    foreach (codes[i]) begin
      exp_src = (codes[i] == 3'h3 || codes[i] > 3'h5) ? 3'h0 : codes[i];
      wr(osc_pkg::OFF_CTRL, {21'h0, codes[i], 8'h03});
      sw_wait();
      check({29'h0, cur_src_o}, {29'h0, exp_src});
      rd(osc_pkg::OFF_CTRL, {21'h0, codes[i], 8'h02});
    end
    check({31'h0, irq_o}, 32'h0000_0000);
    rd(osc_pkg::OFF_IRQ_STS, 32'h0000_0002);
    // Clock failure raises the flag and an unmasked interrupt
    wr(osc_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    @(posedge clk_i) fail_detect_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0000_0001);
    rd(osc_pkg::OFF_CTRL, 32'h0000_070A);
    rd(osc_pkg::OFF_IRQ_STS, 32'h0000_0001);
    fail_detect_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0000_0000);
    wr(osc_pkg::OFF_CTRL, 32'h0000_0702);
    rd(osc_pkg::OFF_CTRL, 32'h0000_0702);
    // Wait instruction: sleep when the bit is set, idle when clear
    wr(osc_pkg::OFF_CTRL, 32'h0000_0712);
    pulse_wait(2'b10);
    wr(osc_pkg::OFF_CTRL, 32'h0000_0702);
    pulse_wait(2'b01);
    // Secondary oscillator off
    wr(osc_pkg::OFF_CTRL, 32'h0000_0700);
    check({31'h0, secondary_osc_en_o}, 32'h0000_0000);
    // Lock, then an attempt to reselect and clear the lock
    wr(osc_pkg::OFF_CTRL, 32'h0000_0782);
    check({31'h0, clk_lock_o}, 32'h0000_0001);
    wr(osc_pkg::OFF_CTRL, 32'h0000_0103);
    rd(osc_pkg::OFF_CTRL, 32'h0000_0782);
    rd(osc_pkg::OFF_IRQ_STS, 32'h0000_0004);
    check({29'h0, cur_src_o}, 32'h0000_0000);
    // Unmapped and write-only places read zero
    rd(8'h20, 32'h0000_0000);
    rd(osc_pkg::OFF_KEY, 32'h0000_0000);
    // Second reset with a plain start-up: no pending switch, secondary off, lock gone
    cfg_boot_src_i <= 3'h5;
    cfg_two_speed_i <= 1'b0;
    cfg_secondary_osc_en_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(osc_pkg::OFF_CTRL, 32'h0000_0500);
    rd(osc_pkg::OFF_STATE, 32'h0000_0005);
    check({31'h0, clk_lock_o}, 32'h0000_0000);
    results();
  end
endmodule
